//--- common/temp_seq_pkg.sv
package temp_seq_pkg;

    // ****************************************************************
    // Timebase and timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS  = 10;
    localparam int TICK_US        = 500;
    localparam int TICK_CYCLES    = TICK_US * 1000 / CLK_PERIOD_NS;
    localparam int POWERUP_US     = 1500;
    localparam int POWERUP_TICKS  = (POWERUP_US + TICK_US - 1) / TICK_US;
    localparam int CONV_TIME_US   = 15500;
    localparam int CONV_TICKS     = CONV_TIME_US / TICK_US;
    localparam int TIMEOUT_MIN_MS = 20;
    localparam int TIMEOUT_MAX_MS = 40;
    // Aim at the middle of the window; the tick grain costs one tick
    localparam int TIMEOUT_TICKS  = (TIMEOUT_MIN_MS + TIMEOUT_MAX_MS) * 1000 / 2 / TICK_US;

    // ****************************************************************
    // Register pointers and configuration layout
    // ****************************************************************
    localparam logic [1:0]  PTR_RESULT   = 2'h0;
    localparam logic [1:0]  PTR_CONFIG   = 2'h1;
    localparam logic [1:0]  PTR_LOW      = 2'h2;
    localparam logic [1:0]  PTR_HIGH     = 2'h3;
    localparam int          CFG_DR_BIT   = 13;
    localparam int          CFG_MODE_LSB = 10;
    localparam int          CFG_CONV_LSB = 7;
    localparam int          CFG_AVG_LSB  = 5;

    // ****************************************************************
    // Reset values and mode codes
    // ****************************************************************
    localparam logic [15:0] RESULT_RESET = 16'h8000;
    localparam logic [15:0] LOW_RESET    = 16'h8000;
    localparam logic [15:0] HIGH_RESET   = 16'h7fff;
    localparam logic [2:0]  CONV_RESET   = 3'h4;
    localparam logic [1:0]  AVG_RESET    = 2'h1;
    localparam logic [1:0]  MODE_CONT    = 2'h0;
    localparam logic [1:0]  MODE_HALT    = 2'h1;
    localparam logic [1:0]  MODE_ONESHOT = 2'h3;
    localparam logic [6:0]  DEV_ADDR     = 7'h48;

    typedef enum logic [2:0] {LP_ADDR, LP_PTR, LP_WMSB, LP_WLSB, LP_READ, LP_IDLE} link_phase_t;
    typedef enum logic [1:0] {SQ_POWERUP, SQ_ACTIVE, SQ_STANDBY, SQ_HALTED} seq_state_t;

    typedef struct packed {
        link_phase_t phase;
        logic [3:0]  bit_idx;
        logic [6:0]  shift;
        logic        acking;
        logic [1:0]  ptr;
        logic [7:0]  wmsb;
        logic [15:0] wdata;
        logic        wr_tog;
        logic        rd_tog;
        logic [15:0] out_sr;
        logic        sda_oe;
        logic        sda_o;
    } link_state_t;

    typedef struct packed {
        logic        scl_s1, scl_s2, scl_s3;
        logic        sda_s1, sda_s2, sda_s3;
        logic        wr_s1, wr_s2, wr_s3;
        logic        rd_s1, rd_s2, rd_s3;
        logic [1:0]  ptr_s1, ptr_s2;
        logic        halt_s1, halt_s2;
        logic        frame;
        logic        link_clear;
        logic [6:0]  idle_ticks;
        logic [15:0] hold;
        logic [16:0] tick_cnt;
        seq_state_t  seq;
        logic [5:0]  step;
        logic [6:0]  conv_done;
        logic [15:0] cyc;
        logic [21:0] acc;
        logic        oneshot;
        logic [15:0] result;
        logic [15:0] low;
        logic [15:0] high;
        logic [1:0]  mode;
        logic [2:0]  conv;
        logic [1:0]  avg;
        logic        data_ready;
        logic        busy;
    } ref_state_t;

endpackage : temp_seq_pkg

//--- rtl/temp_conversion_sequencer.sv
`timescale 1ns/1ps
`default_nettype none

module temp_conversion_sequencer
    import temp_seq_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES
)(
    // System
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    // Serial link
    input  wire logic        scl,
    input  wire logic        sda_i,
    output var  logic        sda_o,
    output var  logic        sda_oe,
    // Converter and strap
    input  wire logic [15:0] adc_sample,
    input  wire logic        start_halted,
    // Status
    output var  logic        conv_busy
);

    // ****************************************************************
    // Decoding helpers
    // ****************************************************************
    function automatic logic [15:0] period_ticks(input logic [2:0] c);
        case (c)
            3'h0:    period_ticks = 16'(CONV_TICKS);
            3'h1:    period_ticks = 16'h00fa;
            3'h2:    period_ticks = 16'h01f4;
            3'h3:    period_ticks = 16'h03e8;
            3'h4:    period_ticks = 16'h07d0;
            3'h5:    period_ticks = 16'h1f40;
            3'h6:    period_ticks = 16'h3e80;
            default: period_ticks = 16'h7d00;
        endcase
    endfunction : period_ticks

    function automatic logic [6:0] avg_count(input logic [1:0] a);
        case (a)
            2'h0:    avg_count = 7'h01;
            2'h1:    avg_count = 7'h08;
            2'h2:    avg_count = 7'h20;
            default: avg_count = 7'h40;
        endcase
    endfunction : avg_count

    function automatic logic [2:0] avg_shift(input logic [1:0] a);
        case (a)
            2'h0:    avg_shift = 3'h0;
            2'h1:    avg_shift = 3'h3;
            2'h2:    avg_shift = 3'h5;
            default: avg_shift = 3'h6;
        endcase
    endfunction : avg_shift

    ref_state_t  r;
    ref_state_t  next_r;
    link_state_t l;
    link_state_t next_l;
    logic        sda_rise;
    wire         link_rst_n = resetn & ~r.link_clear;

    // ****************************************************************
    // Link side, clocked by the serial clock
    // ****************************************************************
    // Data is taken on the rising edge; everything else moves on the
    // falling edge so that the line only changes while the clock is low
    always_ff @(posedge scl or negedge link_rst_n)
    begin
        if (!link_rst_n)
            sda_rise <= 1'b0;
        else
            sda_rise <= sda_i;
    end

    always_comb
    begin
        next_l = l;
        next_l.sda_o = 1'b0;
        next_l.bit_idx = (l.bit_idx >= 4'h8) ? 4'h0 : l.bit_idx + 4'h1;
        if (l.bit_idx < 4'h7)
            next_l.shift = {l.shift[5:0], sda_rise};
        if (l.bit_idx == 4'h7)
        begin
            next_l.sda_oe = 1'b0;
            next_l.acking = 1'b0;
            case (l.phase)
                LP_ADDR:
                begin
                    // Carry the kept pointer in, so a frame with no pointer byte reuses it
                    next_l.ptr = r.ptr_s2;
                    if (l.shift == DEV_ADDR)
                    begin
                        next_l.acking = 1'b1;
                        next_l.sda_oe = 1'b1;
                        if (sda_rise)
                        begin
                            next_l.phase  = LP_READ;
                            // The frozen snapshot keeps a half-updated word off the bus
                            next_l.out_sr = r.hold;
                            next_l.rd_tog = ~l.rd_tog;
                        end
                        else
                            next_l.phase = LP_PTR;
                    end
                    else
                        next_l.phase = LP_IDLE;
                end
                LP_PTR:
                begin
                    next_l.ptr    = sda_rise ? {l.shift[0], 1'b1} : {l.shift[0], 1'b0};
                    next_l.acking = 1'b1;
                    next_l.sda_oe = 1'b1;
                    next_l.phase  = LP_WMSB;
                end
                LP_WMSB:
                begin
                    next_l.wmsb   = {l.shift, sda_rise};
                    next_l.acking = 1'b1;
                    next_l.sda_oe = 1'b1;
                    next_l.phase  = LP_WLSB;
                end
                LP_WLSB:
                begin
                    next_l.wdata  = {l.wmsb, l.shift, sda_rise};
                    next_l.wr_tog = ~l.wr_tog;
                    next_l.acking = 1'b1;
                    next_l.sda_oe = 1'b1;
                    next_l.phase  = LP_IDLE;
                end
                default:
                    next_l.phase = l.phase;
            endcase
        end
        else if (l.bit_idx == 4'h8)
        begin
            next_l.acking = 1'b0;
            next_l.sda_oe = 1'b0;
            if (l.phase == LP_READ && (l.acking || !sda_rise))
            begin
                next_l.sda_oe = ~l.out_sr[15];
                next_l.out_sr = {l.out_sr[14:0], 1'b0};
            end
            else if (l.phase == LP_READ)
                next_l.phase = LP_IDLE;
        end
        else if (l.phase == LP_READ && l.bit_idx < 4'h7)
        begin
            next_l.sda_oe = ~l.out_sr[15];
            next_l.out_sr = {l.out_sr[14:0], 1'b0};
        end
    end

    // Start, stop and timeout all reset this side, which also lets go of the line
    always_ff @(negedge scl or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            l         <= '0;
            l.phase   <= LP_ADDR;
            l.bit_idx <= 4'hf;
        end
        else
            l <= next_l;
    end

    // ****************************************************************
    // Register side, clocked by the reference clock
    // ****************************************************************
    logic        tick;
    logic        start_det;
    logic        stop_det;
    logic        wr_evt;
    logic        rd_evt;
    logic        dr_set;
    logic [21:0] acc_new;
    logic [15:0] cfg_word;
    logic [1:0]  ptr_now;

    always_comb
    begin
        next_r = r;
        dr_set = 1'b0;
        next_r.scl_s1  = scl;
        next_r.scl_s2  = r.scl_s1;
        next_r.scl_s3  = r.scl_s2;
        next_r.sda_s1  = sda_i;
        next_r.sda_s2  = r.sda_s1;
        next_r.sda_s3  = r.sda_s2;
        next_r.wr_s1   = l.wr_tog;
        next_r.wr_s2   = r.wr_s1;
        next_r.wr_s3   = r.wr_s2;
        next_r.rd_s1   = l.rd_tog;
        next_r.rd_s2   = r.rd_s1;
        next_r.rd_s3   = r.rd_s2;
        next_r.ptr_s1  = l.ptr;
        next_r.halt_s1 = start_halted;
        next_r.halt_s2 = r.halt_s1;
        start_det = r.scl_s2 && r.scl_s3 && r.sda_s3 && !r.sda_s2;
        stop_det  = r.scl_s2 && r.scl_s3 && !r.sda_s3 && r.sda_s2;
        // The link side forgets its pointer at every start and stop, so it is
        // kept here once the address byte of a frame has gone by
        ptr_now   = ((start_det || stop_det) && r.frame && l.phase != LP_ADDR) ?
                    r.ptr_s1 : r.ptr_s2;
        next_r.ptr_s2 = ptr_now;
        wr_evt    = r.wr_s2 ^ r.wr_s3;
        rd_evt    = r.rd_s2 ^ r.rd_s3;
        tick      = (r.tick_cnt == 17'(TICK_CYC - 1));
        next_r.tick_cnt = tick ? 17'h0_0000 : r.tick_cnt + 17'h0_0001;
        acc_new   = r.acc + {{6{adc_sample[15]}}, adc_sample};
        cfg_word  = 16'h0000;
        cfg_word[CFG_DR_BIT] = r.data_ready;
        cfg_word[CFG_MODE_LSB +: 2] = r.mode;
        cfg_word[CFG_CONV_LSB +: 3] = r.conv;
        cfg_word[CFG_AVG_LSB +: 2]  = r.avg;

        // Bus framing and stall watchdog
        next_r.link_clear = 1'b0;
        if (start_det)
        begin
            next_r.frame      = 1'b1;
            next_r.link_clear = 1'b1;
            next_r.idle_ticks = 7'h00;
            case (ptr_now)
                PTR_RESULT: next_r.hold = r.result;
                PTR_CONFIG: next_r.hold = cfg_word;
                PTR_LOW:    next_r.hold = r.low;
                default:    next_r.hold = r.high;
            endcase
        end
        else if (stop_det)
        begin
            next_r.frame      = 1'b0;
            next_r.link_clear = 1'b1;
        end
        else if (r.frame)
        begin
            if (r.scl_s2 != r.scl_s3)
                next_r.idle_ticks = 7'h00;
            else if (r.idle_ticks == 7'(TIMEOUT_TICKS))
            begin
                next_r.frame      = 1'b0;
                next_r.link_clear = 1'b1;
                next_r.idle_ticks = 7'h00;
            end
            else if (tick)
                next_r.idle_ticks = r.idle_ticks + 7'h01;
        end

        // ****************************************************************
        // Conversion sequencer
        // ****************************************************************
        case (r.seq)
            SQ_POWERUP:
            begin
                if (tick)
                    next_r.step = r.step + 6'h01;
                if (tick && r.step == 6'(POWERUP_TICKS - 1))
                begin
                    next_r.step = 6'h00;
                    if (r.halt_s2)
                    begin
                        next_r.mode = MODE_HALT;
                        next_r.seq  = SQ_HALTED;
                    end
                    else
                    begin
                        next_r.seq       = SQ_ACTIVE;
                        next_r.cyc       = 16'h0000;
                        next_r.conv_done = 7'h00;
                        next_r.acc       = 22'h00_0000;
                    end
                end
            end
            SQ_ACTIVE:
            begin
                if (tick)
                begin
                    next_r.cyc  = r.cyc + 16'h0001;
                    next_r.step = r.step + 6'h01;
                    if (r.step == 6'(CONV_TICKS - 1))
                    begin
                        next_r.step      = 6'h00;
                        next_r.acc       = acc_new;
                        next_r.conv_done = r.conv_done + 7'h01;
                        if (r.conv_done + 7'h01 == avg_count(r.avg))
                        begin
                            // Only a whole set ever reaches the result
                            next_r.result = 16'($signed(acc_new) >>> avg_shift(r.avg));
                            dr_set = 1'b1;
                            if (r.oneshot)
                            begin
                                next_r.oneshot = 1'b0;
                                next_r.mode    = MODE_HALT;
                                next_r.seq     = SQ_HALTED;
                            end
                            else
                                next_r.seq = SQ_STANDBY;
                        end
                    end
                end
            end
            SQ_STANDBY:
            begin
                if (r.cyc >= period_ticks(r.conv))
                begin
                    next_r.seq       = SQ_ACTIVE;
                    next_r.cyc       = 16'h0000;
                    next_r.step      = 6'h00;
                    next_r.conv_done = 7'h00;
                    next_r.acc       = 22'h00_0000;
                end
                else if (tick)
                    next_r.cyc = r.cyc + 16'h0001;
            end
            SQ_HALTED:
                next_r.seq = SQ_HALTED;
            default:
                next_r.seq = SQ_POWERUP;
        endcase

        // ****************************************************************
        // Register writes from the link
        // ****************************************************************
        // Word and pointer are quiet for at least the acknowledge link clock after the toggle
        if (wr_evt)
        begin
            // Pointer byte came many link clocks before the word, so it is settled
            case (r.ptr_s1)
                PTR_CONFIG:
                begin
                    next_r.conv = l.wdata[CFG_CONV_LSB +: 3];
                    next_r.avg  = l.wdata[CFG_AVG_LSB +: 2];
                    case (l.wdata[CFG_MODE_LSB +: 2])
                        MODE_HALT:
                        begin
                            next_r.mode    = MODE_HALT;
                            next_r.oneshot = 1'b0;
                            if (r.seq != SQ_POWERUP)
                                next_r.seq = SQ_HALTED;
                        end
                        MODE_ONESHOT:
                        begin
                            if (r.seq == SQ_HALTED)
                            begin
                                next_r.mode      = MODE_ONESHOT;
                                next_r.oneshot   = 1'b1;
                                next_r.seq       = SQ_ACTIVE;
                                next_r.cyc       = 16'h0000;
                                next_r.step      = 6'h00;
                                next_r.conv_done = 7'h00;
                                next_r.acc       = 22'h00_0000;
                            end
                        end
                        default:
                        begin
                            next_r.mode = l.wdata[CFG_MODE_LSB +: 2];
                            if (r.seq == SQ_HALTED)
                            begin
                                next_r.seq       = SQ_ACTIVE;
                                next_r.oneshot   = 1'b0;
                                next_r.cyc       = 16'h0000;
                                next_r.step      = 6'h00;
                                next_r.conv_done = 7'h00;
                                next_r.acc       = 22'h00_0000;
                            end
                        end
                    endcase
                end
                PTR_LOW:  next_r.low  = l.wdata;
                PTR_HIGH: next_r.high = l.wdata;
                default:  next_r.low  = r.low;
            endcase
        end

        // A set end in the same cycle as a clearing read wins
        next_r.data_ready = dr_set | (r.data_ready & ~(rd_evt &&
                            (r.ptr_s2 == PTR_RESULT || r.ptr_s2 == PTR_CONFIG)));
        next_r.busy = (next_r.seq == SQ_ACTIVE);
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            r        <= '0;
            r.seq    <= SQ_POWERUP;
            r.result <= RESULT_RESET;
            r.low    <= LOW_RESET;
            r.high   <= HIGH_RESET;
            r.mode   <= MODE_CONT;
            r.conv   <= CONV_RESET;
            r.avg    <= AVG_RESET;
        end
        else
            r <= next_r;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign sda_o     = l.sda_o;
    assign sda_oe    = l.sda_oe;
    assign conv_busy = r.busy;

endmodule : temp_conversion_sequencer

`default_nettype wire

//--- dv/i2c_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model
    import temp_seq_pkg::*;
(
    // Bus pins
    input  wire logic sda_o,
    input  wire logic sda_oe,
    output var  logic scl,
    output wire logic sda_line
);
    logic       host_low = 1'b0;
    logic [7:0] junk;
    // Pull-up: a released line reads high, never the last driven value
    assign sda_line = !(host_low || (sda_oe && !sda_o));
    initial scl = 1'b1;
    task automatic bit_io(input logic b, output logic r);
        host_low = !b;
        #80 scl = 1'b1;
        r = sda_line;
        #80 scl = 1'b0;
    endtask : bit_io
    // Odd offset keeps the link clock out of step with the reference clock
    task automatic start_frame();
        #83 host_low = 1'b1;
        #80 scl = 1'b0;
    endtask : start_frame
    task automatic stop_frame();
        host_low = 1'b1;
        #80 scl = 1'b1;
        #80 host_low = 1'b0;
        #80;
    endtask : stop_frame
    task automatic xfer(input logic [7:0] v, input logic last, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) bit_io(v[i], r[i]);
        bit_io(last, junk[0]);
    endtask : xfer
    task automatic write_word(input logic [1:0] p, input logic [15:0] d);
        start_frame();
        xfer({DEV_ADDR, 1'b0}, 1'b1, junk);
        xfer({6'h00, p}, 1'b1, junk);
        xfer(d[15:8], 1'b1, junk);
        xfer(d[7:0], 1'b1, junk);
        stop_frame();
    endtask : write_word
    task automatic read_word(input logic [1:0] p, output logic [15:0] d);
        start_frame();
        xfer({DEV_ADDR, 1'b0}, 1'b1, junk);
        xfer({6'h00, p}, 1'b1, junk);
        stop_frame();
        start_frame();
        xfer({DEV_ADDR, 1'b1}, 1'b1, junk);
        xfer(8'hff, 1'b0, d[15:8]);
        xfer(8'hff, 1'b1, d[7:0]);
        stop_frame();
    endtask : read_word
endmodule : i2c_host_model
`default_nettype wire

//--- dv/temp_conversion_sequencer_checker.sv
`timescale 1ns/1ps
`default_nettype none
module seq_checker
    import temp_seq_pkg::*;
#(parameter int TICK_CYC = TICK_CYCLES)
(
    // Watched ports
    input wire logic        ref_clk, resetn, scl, sda_i, sda_o, sda_oe,
    input wire logic        start_halted, conv_busy,
    input wire logic [15:0] adc_sample
);
    int   up_n, still_n, busy_n;
    logic scl_q;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // Counters stand in for repetitions far too long to unroll
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            up_n    <= 0;
            still_n <= 0;
            busy_n  <= 0;
            scl_q   <= 1'b1;
        end
        else
        begin
            up_n    <= (up_n < 3 * TICK_CYC) ? up_n + 1 : up_n;
            still_n <= (scl != scl_q) ? 0 : still_n + 1;
            busy_n  <= conv_busy ? busy_n + 1 : 0;
            scl_q   <= scl;
        end
    end
    sequence busy_start; $rose(conv_busy); endsequence
    sequence busy_hold; conv_busy [*8]; endsequence
    a_reset_quiet: assert property (disable iff (1'b0) !resetn |=> !sda_oe && !conv_busy)
        else $error("outputs active during reset");
    a_powerup_wait: assert property (conv_busy |-> up_n >= 3 * TICK_CYC - 2)
        else $error("conversion before power-up interval");
    a_open_drain: assert property (sda_o == 1'b0)
        else $error("data line driven high");
    a_ack_on_low: assert property ($rose(sda_oe) |-> !scl)
        else $error("data line taken while clock high");
    a_oe_held_high: assert property (scl && $past(scl) |-> $stable(sda_oe))
        else $error("data line moved while clock high");
    a_timeout_release: assert property (still_n > 62 * TICK_CYC |-> !sda_oe)
        else $error("data line held after clock stall");
    a_busy_min: assert property (busy_start |-> busy_hold)
        else $error("active phase too short");
    a_busy_max: assert property (busy_n <= 1986 * TICK_CYC)
        else $error("active phase too long");
endmodule : seq_checker
bind temp_conversion_sequencer seq_checker #(.TICK_CYC(TICK_CYC)) chk_i (.ref_clk(ref_clk),
    .resetn(resetn), .scl(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .start_halted(start_halted), .conv_busy(conv_busy), .adc_sample(adc_sample));
`default_nettype wire

//--- dv/temp_conversion_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module temp_conversion_sequencer_bench
    import temp_seq_pkg::*;
;
    localparam int TK = 200;
    logic        ref_clk = 1'b0, resetn = 1'b0, start_halted = 1'b1;
    logic        scl, sda_o, sda_oe, conv_busy;
    logic [15:0] adc_sample = 16'h0c80, v;
    wire logic   sda_line;
    int          errors = 0, comparisons = 0, cycles = 0;
    always #5 ref_clk = ~ref_clk;
    temp_conversion_sequencer #(.TICK_CYC(TK)) DUT (.ref_clk(ref_clk), .resetn(resetn),
        .scl(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
        .adc_sample(adc_sample), .start_halted(start_halted), .conv_busy(conv_busy));
    i2c_host_model host (.sda_o(sda_o), .sda_oe(sda_oe), .scl(scl), .sda_line(sda_line));
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc
    task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : check
    task automatic rd(input string n, input logic [1:0] p, input logic [15:0] e);
        host.read_word(p, v);
        check(n, e, v);
        cyc(1);
    endtask : rd
    task automatic wait_busy(input logic lv, input int lim);
        for (int n = 0; n < lim && conv_busy !== lv; n++) cyc(1);
        check("busy", {15'h0000, lv}, {15'h0000, conv_busy});
    endtask : wait_busy
    task automatic complete_run();
        if (errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 90000) check("cycle limit", 16'h0000, 16'h0001);
        if (cycles == 90000) complete_run();
    end
    initial
    begin
        cyc(20);
        resetn = 1'b1;
        cyc(5);
        rd("result", PTR_RESULT, RESULT_RESET);
        rd("config", PTR_CONFIG, 16'h0620);
        rd("low", PTR_LOW, LOW_RESET);
        rd("high", PTR_HIGH, HIGH_RESET);
        wait_busy(1'b0, 1);
        // Stall the clock while the device drives the first data bit low
        host.start_frame();
        host.xfer({DEV_ADDR, 1'b1}, 1'b1, v);
        cyc(58 * TK);
        check("sda_oe", 16'h0001, {15'h0000, sda_oe});
        cyc(4 * TK);
        check("sda_oe", 16'h0000, {15'h0000, sda_oe});
        host.stop_frame();
        host.write_word(PTR_CONFIG, 16'h0000);
        wait_busy(1'b1, 100);
        cyc(30 * TK - 10);
        wait_busy(1'b1, 1);
        wait_busy(1'b0, 2 * TK + 20);
        rd("config", PTR_CONFIG, 16'h2000);
        rd("config", PTR_CONFIG, 16'h0000);
        rd("result", PTR_RESULT, 16'h0c80);
        adc_sample = 16'h3200;
        rd("result", PTR_RESULT, 16'h0c80);
        wait_busy(1'b0, 31 * TK);
        rd("result", PTR_RESULT, 16'h3200);
        adc_sample = 16'hfff0;
        host.write_word(PTR_CONFIG, 16'h0400);
        wait_busy(1'b0, 5);
        cyc(31 * TK);
        rd("result", PTR_RESULT, 16'h3200);
        host.write_word(PTR_CONFIG, 16'h0c00);
        wait_busy(1'b1, 50);
        wait_busy(1'b0, 32 * TK);
        rd("config", PTR_CONFIG, 16'h2400);
        rd("result", PTR_RESULT, 16'hfff0);
        cyc(32 * TK);
        wait_busy(1'b0, 1);
        complete_run();
    end
endmodule : temp_conversion_sequencer_bench
`default_nettype wire
